// file: core/crf_core.sv
// CPU register file: banked registers, pointers, flags and APB view.
`timescale 1ns/100ps
`default_nettype none
module crf_core #(
    parameter int NUM_BANKS = 2
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [crf_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Datapath write, flag update and program counter
    input  wire crf_pkg::crf_wr_s         dp_wr,
    input  wire crf_pkg::crf_alu_s        dp_alu,
    input  wire crf_pkg::crf_pc_s         dp_pc,
    // Datapath read ports
    input  wire crf_pkg::crf_rd_s         rd_a,
    input  wire crf_pkg::crf_rd_s         rd_b,
    output logic      [31:0]              rd_a_data,
    output logic      [31:0]              rd_b_data,
    // Interrupt sequencer
    input  wire crf_pkg::crf_int_s        intr,
    output logic                          irq_permit,
    // State views
    output logic      [15:0]              flags,
    output logic      [crf_pkg::AW-1:0]   pc
);
    import crf_pkg::*;

    // Bank select is a single flag bit, so exactly two banks exist
    if (NUM_BANKS != 2) begin : g_bank_check
        $error("crf_core: NUM_BANKS must be 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [DW-1:0] data_r [0:NUM_BANKS-1][0:3];
    logic [AW-1:0] ptr_r  [0:NUM_BANKS-1][0:3];
    logic [AW-1:0] pc_r;
    logic [AW-1:0] vtb_r;
    logic [AW-1:0] usp_r;
    logic [AW-1:0] isp_r;
    logic [15:0]   flg_r;
    logic [15:0]   flg_nxt;
    logic [31:0]   prdata_r;
    logic          pready_r;
    logic          pslverr_r;
    logic [31:0]   rd_a_r;
    logic [31:0]   rd_b_r;
    logic          irq_permit_r;
    logic          bank;
    logic          ustk;
    logic [2:0]    processor_priority_level;

    // Live selections from the flag register
    assign bank = flg_r[FLG_B];
    assign ustk = flg_r[FLG_U];
    assign processor_priority_level  = flg_r[FLG_IPL_HI:FLG_IPL_LO];

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Stack pointer in use
    function automatic logic [AW-1:0] active_sp();
        return ustk ? usp_r : isp_r;
    endfunction

    // Datapath view of a register at the given size
    function automatic logic [31:0] read_sel(input crf_sel_e sel,
                                             input crf_size_e sz);
        logic [DW-1:0] w;
        logic [DW-1:0] up;
        w  = data_r[bank][sel[1:0]];
        up = data_r[bank][{1'b1, sel[0]}];
        case (sel)
            SEL_D0, SEL_D1: begin
                case (sz)
                    SZ_LO:   read_sel = {24'h000000, w[7:0]};
                    SZ_HI:   read_sel = {24'h000000, w[15:8]};
                    SZ_LONG: read_sel = {up, w};
                    default: read_sel = {16'h0000, w};
                endcase
            end
            SEL_D2, SEL_D3: read_sel = {16'h0000, w};
            SEL_A0, SEL_A1, SEL_SB, SEL_FB: begin
                read_sel = {8'h00, ptr_r[bank][sel[1:0]]};
            end
            SEL_VTB: read_sel = {8'h00, vtb_r};
            SEL_USP: read_sel = {8'h00, usp_r};
            SEL_ISP: read_sel = {8'h00, isp_r};
            SEL_ASP: read_sel = {8'h00, active_sp()};
            SEL_FLG: read_sel = {16'h0000, flg_r & FLG_USED};
            SEL_PC:  read_sel = {8'h00, pc_r};
            default: read_sel = 32'h00000000;
        endcase
    endfunction

    // APB address is a known register
    function automatic logic apb_hit(input logic [APB_AW-1:0] a);
        if (a[1:0] != 2'b00) begin
            return 1'b0;
        end
        return (a < OFS_PC) || (a == OFS_PC) || (a == OFS_VTB) ||
               (a == OFS_USP) || (a == OFS_ISP) || (a == OFS_FLG) ||
               (a == OFS_ASP);
    endfunction

    // APB read value of a known register
    function automatic logic [31:0] apb_read(input logic [APB_AW-1:0] a);
        if (a < OFS_PC) begin
            if (a[4]) begin
                return {8'h00, ptr_r[a[5]][a[3:2]]};
            end
            return {16'h0000, data_r[a[5]][a[3:2]]};
        end
        case (a)
            OFS_PC:  return {8'h00, pc_r};
            OFS_VTB: return {8'h00, vtb_r};
            OFS_USP: return {8'h00, usp_r};
            OFS_ISP: return {8'h00, isp_r};
            OFS_FLG: return {16'h0000, flg_r & FLG_USED};
            OFS_ASP: return {8'h00, active_sp()};
            default: return 32'h00000000;
        endcase
    endfunction

    // Zero test of an ALU result at its size
    function automatic logic res_zero(input crf_size_e sz, input logic [31:0] r);
        case (sz)
            SZ_LO, SZ_HI: return r[7:0] == 8'h00;
            SZ_WORD:      return r[15:0] == 16'h0000;
            default:      return r == 32'h00000000;
        endcase
    endfunction

    // Sign bit of an ALU result at its size
    function automatic logic res_sign(input crf_size_e sz, input logic [31:0] r);
        case (sz)
            SZ_LO, SZ_HI: return r[7];
            SZ_WORD:      return r[15];
            default:      return r[31];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB slave
    logic apb_setup_acc;
    logic apb_fire_wr;
    logic apb_ro;

    // First access cycle is answered one cycle later
    assign apb_setup_acc = psel & penable & ~pready_r;
    assign apb_fire_wr   = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign apb_ro        = (paddr == OFS_PC) || (paddr == OFS_ASP);

    // Ready, error and read data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else if (apb_setup_acc) begin
            pready_r  <= 1'b1;
            pslverr_r <= ~apb_hit(paddr) | (pwrite & apb_ro);
            prdata_r  <= (pwrite | ~apb_hit(paddr)) ? 32'h00000000 : apb_read(paddr);
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data registers, datapath write wins over APB
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                for (int i = 0; i < 4; i++) begin
                    data_r[b][i] <= DATA_RST;
                end
            end
        end else begin
            if (apb_fire_wr && paddr < OFS_PC && !paddr[4]) begin
                data_r[paddr[5]][paddr[3:2]] <= pwdata[DW-1:0];
            end
            if (dp_wr.en && (dp_wr.sel == SEL_D0 || dp_wr.sel == SEL_D1)) begin
                case (dp_wr.size)
                    SZ_LO: data_r[bank][dp_wr.sel[1:0]][7:0] <= dp_wr.data[7:0];
                    SZ_HI: data_r[bank][dp_wr.sel[1:0]][15:8] <= dp_wr.data[7:0];
                    SZ_LONG: begin
                        data_r[bank][{1'b0, dp_wr.sel[0]}] <= dp_wr.data[15:0];
                        data_r[bank][{1'b1, dp_wr.sel[0]}] <= dp_wr.data[31:16];
                    end
                    default: data_r[bank][{1'b0, dp_wr.sel[0]}] <= dp_wr.data[15:0];
                endcase
            end else if (dp_wr.en && (dp_wr.sel == SEL_D2 || dp_wr.sel == SEL_D3)) begin
                data_r[bank][dp_wr.sel[1:0]] <= dp_wr.data[15:0];
            end
        end
    end

    // Address and base registers of both banks
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                for (int i = 0; i < 4; i++) begin
                    ptr_r[b][i] <= PTR_RST;
                end
            end
        end else begin
            if (apb_fire_wr && paddr < OFS_PC && paddr[4]) begin
                ptr_r[paddr[5]][paddr[3:2]] <= pwdata[AW-1:0];
            end
            if (dp_wr.en && dp_wr.sel[3:2] == 2'b01) begin
                ptr_r[bank][dp_wr.sel[1:0]] <= dp_wr.data[AW-1:0];
            end
        end
    end

    // Vector table base and both stack pointers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vtb_r <= PTR_RST;
            usp_r <= PTR_RST;
            isp_r <= PTR_RST;
        end else begin
            if (apb_fire_wr && paddr == OFS_VTB) begin
                vtb_r <= pwdata[AW-1:0];
            end
            if (apb_fire_wr && paddr == OFS_USP) begin
                usp_r <= pwdata[AW-1:0];
            end
            if (apb_fire_wr && paddr == OFS_ISP) begin
                isp_r <= pwdata[AW-1:0];
            end
            if (dp_wr.en && dp_wr.sel == SEL_VTB) begin
                vtb_r <= dp_wr.data[AW-1:0];
            end
            if (dp_wr.en && (dp_wr.sel == SEL_USP || (dp_wr.sel == SEL_ASP && ustk))) begin
                usp_r <= dp_wr.data[AW-1:0];
            end
            if (dp_wr.en && (dp_wr.sel == SEL_ISP || (dp_wr.sel == SEL_ASP && !ustk))) begin
                isp_r <= dp_wr.data[AW-1:0];
            end
        end
    end

    // Program counter, loaded by the datapath only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_r <= PTR_RST;
        end else if (dp_pc.load) begin
            pc_r <= dp_pc.value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag register: writes, then ALU results, then interrupt entry
    always_comb begin
        flg_nxt = flg_r;
        if (apb_fire_wr && paddr == OFS_FLG) begin
            flg_nxt = pwdata[15:0] & FLG_USED;
        end
        if (dp_wr.en && dp_wr.sel == SEL_FLG) begin
            flg_nxt = dp_wr.data[15:0] & FLG_USED;
        end
        if (dp_alu.en) begin
            if (dp_alu.upd[UPD_C]) begin
                flg_nxt[FLG_C] = dp_alu.carry;
            end
            if (dp_alu.upd[UPD_Z]) begin
                flg_nxt[FLG_Z] = res_zero(dp_alu.size, dp_alu.result);
            end
            if (dp_alu.upd[UPD_S]) begin
                flg_nxt[FLG_S] = res_sign(dp_alu.size, dp_alu.result);
            end
            if (dp_alu.upd[UPD_O]) begin
                flg_nxt[FLG_O] = dp_alu.ovf;
            end
        end
        if (intr.hw_accept || intr.sw_exec) begin
            flg_nxt[FLG_I] = 1'b0;
        end
        if (intr.hw_accept || (intr.sw_exec && intr.sw_vec < SW_VEC_LIMIT)) begin
            flg_nxt[FLG_U] = 1'b0;
        end
    end

    // Flag register state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flg_r <= FLG_RST;
        end else begin
            flg_r <= flg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Maskable interrupt permission
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_permit_r <= 1'b0;
        end else begin
            irq_permit_r <= intr.req_valid & flg_r[FLG_I]
                            & (intr.req_level > processor_priority_level);
        end
    end

    // Datapath read ports, one cycle latency
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_a_r <= 32'h00000000;
            rd_b_r <= 32'h00000000;
        end else begin
            rd_a_r <= read_sel(rd_a.sel, rd_a.size);
            rd_b_r <= read_sel(rd_b.sel, rd_b.size);
        end
    end

    // Outputs from flip-flops
    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign rd_a_data  = rd_a_r;
    assign rd_b_data  = rd_b_r;
    assign irq_permit = irq_permit_r;
    assign flags      = flg_r;                    // Reserved bits are never stored
    assign pc         = pc_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_irq_blocked: assert property (@(posedge clk) disable iff (sys_rst)
        !flg_r[FLG_I] |=> !irq_permit_r)
        else $error("interrupt permitted while disabled");

    a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        irq_permit_r |-> $past(intr.req_level) > $past(processor_priority_level))
        else $error("interrupt permitted at or below level");

    a_accept_clear_i: assert property (@(posedge clk) disable iff (sys_rst)
        intr.hw_accept |=> !flg_r[FLG_I])
        else $error("enable flag kept after accept");

    a_hw_stack_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (intr.hw_accept || (intr.sw_exec && intr.sw_vec < SW_VEC_LIMIT)) |=> !flg_r[FLG_U])
        else $error("stack flag kept after interrupt entry");

    a_active_stack: assert property (@(posedge clk) disable iff (sys_rst)
        rd_a.sel == SEL_ASP |=>
            rd_a_r == {8'h00, ($past(ustk) ? $past(usp_r) : $past(isp_r))})
        else $error("wrong active stack pointer");

    a_zero_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (dp_alu.en && dp_alu.upd[UPD_Z]) |=>
            flg_r[FLG_Z] == res_zero($past(dp_alu.size), $past(dp_alu.result)))
        else $error("zero flag mismatch");

    a_sign_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (dp_alu.en && dp_alu.upd[UPD_S] && dp_alu.size == SZ_WORD) |=>
            flg_r[FLG_S] == $past(dp_alu.result[15]))
        else $error("sign flag mismatch");

    a_carry_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (dp_alu.en && dp_alu.upd[UPD_C]) |=> flg_r[FLG_C] == $past(dp_alu.carry))
        else $error("carry flag mismatch");

    a_ovf_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (dp_alu.en && dp_alu.upd[UPD_O]) |=> flg_r[FLG_O] == $past(dp_alu.ovf))
        else $error("overflow flag mismatch");

    a_long_pair: assert property (@(posedge clk) disable iff (sys_rst)
        (dp_wr.en && dp_wr.sel[3:1] == 3'b000 && dp_wr.size == SZ_LONG) |=>
            data_r[$past(bank)][{1'b1, $past(dp_wr.sel[0])}] == $past(dp_wr.data[31:16]))
        else $error("long write missed upper register");

    a_byte_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (dp_wr.en && dp_wr.sel == SEL_D0 && dp_wr.size == SZ_HI && !apb_fire_wr) |=>
            data_r[$past(bank)][0][7:0] == $past(data_r[bank][0][7:0]))
        else $error("upper byte write disturbed lower byte");

    a_apb_answer: assert property (@(posedge clk) disable iff (sys_rst)
        apb_setup_acc |=> pready_r ##1 !pready_r)
        else $error("APB answer not one cycle");

endmodule
`default_nettype wire

// file: core/crf_pkg.sv
// Constants, selectors and carrier structs for the CPU register file.
// Operation
// - Two banks of eight general registers.
// - Bank flag picks bank zero or one.
// - Four 16-bit data registers.
// - First two data registers split into bytes.
// - Pairs zero-two, one-three form 32-bit registers.
// - Two 24-bit address registers.
// - 24-bit static and frame base registers.
// - 24-bit program counter holds next instruction.
// - 24-bit vector table base register.
// - Separate 24-bit user and interrupt stack pointers.
// - Stack flag picks interrupt or user pointer.
// - Interrupt entry clears the stack select flag; software vectors 32 and up leave it set.
// - 16-bit flag register holds processor state.
// - Carry flag reports carry or borrow.
// - Zero flag marks a zero result.
// - Sign flag marks a negative result.
// - Overflow flag marks an overflowing result.
// - Interrupt enable flag gates maskable interrupts.
// - Accepting an interrupt clears interrupt enable.
// - Request needs priority above the level field.
// - Reserved flag bits written zero, read undefined.
package crf_pkg;

    localparam int AW     = 24;
    localparam int DW     = 16;
    localparam int APB_AW = 8;

    // Register byte offsets on the APB slave
    localparam logic [APB_AW-1:0] OFS_BANK0 = 8'h00;
    localparam logic [APB_AW-1:0] OFS_BANK1 = 8'h20;
    localparam logic [APB_AW-1:0] OFS_PC    = 8'h40;
    localparam logic [APB_AW-1:0] OFS_VTB   = 8'h44;
    localparam logic [APB_AW-1:0] OFS_USP   = 8'h48;
    localparam logic [APB_AW-1:0] OFS_ISP   = 8'h4C;
    localparam logic [APB_AW-1:0] OFS_FLG   = 8'h50;
    localparam logic [APB_AW-1:0] OFS_ASP   = 8'h54;

    // Flag register field positions
    localparam int FLG_C      = 0;
    localparam int FLG_D      = 1;
    localparam int FLG_Z      = 2;
    localparam int FLG_S      = 3;
    localparam int FLG_B      = 4;
    localparam int FLG_O      = 5;
    localparam int FLG_I      = 6;
    localparam int FLG_U      = 7;
    localparam int FLG_IPL_LO = 12;
    localparam int FLG_IPL_HI = 14;
    localparam logic [15:0] FLG_USED = 16'h70FF;

    // Reset values
    localparam logic [15:0]   FLG_RST  = 16'h0000;
    localparam logic [DW-1:0] DATA_RST = 16'h0000;
    localparam logic [AW-1:0] PTR_RST  = 24'h000000;

    // Software vectors below this limit switch to the interrupt stack
    localparam logic [5:0] SW_VEC_LIMIT = 6'h20;

    // Flag update mask bits of the ALU port
    localparam int UPD_C = 0;
    localparam int UPD_Z = 1;
    localparam int UPD_S = 2;
    localparam int UPD_O = 3;

    typedef enum logic [3:0] {
        SEL_D0  = 4'h0, SEL_D1  = 4'h1, SEL_D2  = 4'h2, SEL_D3  = 4'h3,
        SEL_A0  = 4'h4, SEL_A1  = 4'h5, SEL_SB  = 4'h6, SEL_FB  = 4'h7,
        SEL_VTB = 4'h8, SEL_USP = 4'h9, SEL_ISP = 4'hA, SEL_ASP = 4'hB,
        SEL_FLG = 4'hC, SEL_PC  = 4'hD, SEL_NA0 = 4'hE, SEL_NA1 = 4'hF
    } crf_sel_e;

    typedef enum logic [1:0] {
        SZ_LO   = 2'b00,
        SZ_HI   = 2'b01,
        SZ_WORD = 2'b10,
        SZ_LONG = 2'b11
    } crf_size_e;

    typedef struct packed {
        logic      en;
        crf_sel_e  sel;
        crf_size_e size;
        logic [31:0] data;
    } crf_wr_s;

    typedef struct packed {
        crf_sel_e  sel;
        crf_size_e size;
    } crf_rd_s;

    typedef struct packed {
        logic      en;
        crf_size_e size;
        logic [31:0] result;
        logic      carry;
        logic      ovf;
        logic [3:0] upd;
    } crf_alu_s;

    typedef struct packed {
        logic       hw_accept;
        logic       sw_exec;
        logic [5:0] sw_vec;
        logic       req_valid;
        logic [2:0] req_level;
    } crf_int_s;

    typedef struct packed {
        logic          load;
        logic [AW-1:0] value;
    } crf_pc_s;

endpackage

// file: test/crf_dp_model.sv
// Datapath and interrupt sequencer model that drives the register file.
`timescale 1ns/100ps
`default_nettype none
module crf_dp_model (
    // Clock
    input  wire logic             clk,
    // Datapath and sequencer requests
    output var crf_pkg::crf_wr_s  dp_wr,
    output var crf_pkg::crf_alu_s dp_alu,
    output var crf_pkg::crf_pc_s  dp_pc,
    output var crf_pkg::crf_rd_s  rd_a,
    output var crf_pkg::crf_rd_s  rd_b,
    output var crf_pkg::crf_int_s intr
);
    import crf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // All requests idle from time zero
    initial begin
        dp_wr = '0;
        dp_alu = '0;
        dp_pc = '0;
        rd_a = '0;
        rd_b = '0;
        intr = '0;
    end

    // One request for one cycle; strobes drop at the edge that takes it
    task automatic cyc(input crf_wr_s w, input crf_alu_s a, input crf_pc_s p,
                       input crf_rd_s r, input crf_int_s i);
        @(posedge clk);
        dp_wr <= w;
        dp_alu <= a;
        dp_pc <= p;
        rd_a <= r;
        rd_b <= r;
        intr <= i;
        @(posedge clk);
        dp_wr <= '0;
        dp_alu <= '0;
        dp_pc <= '0;
        intr <= '0;
        #1;
    endtask
endmodule
`default_nettype wire

// file: test/cpu_register_file_flags_tb.sv
// Self-checking bench for the register file over APB and the datapath model.
`timescale 1ns/100ps
`default_nettype none
module cpu_register_file_flags_tb;
    import crf_pkg::*;

    logic         clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = '0;
    logic [31:0]  pwdata = '0;
    logic [31:0]  prdata, rd_a_data, rd_b_data, r;
    logic         pready, pslverr, irq_permit, e;
    logic [15:0]  flags;
    logic [23:0]  pc;
    crf_wr_s      dp_wr;
    crf_alu_s     dp_alu;
    crf_pc_s      dp_pc;
    crf_rd_s      rd_a, rd_b;
    crf_int_s     intr;
    int           err_count = 0;
    int           samples_checked = 0;
    logic [7:0]   ptr_ofs [7] = '{8'h10, 8'h14, 8'h18, 8'h1C, OFS_VTB, OFS_USP, OFS_ISP};
    crf_size_e    alu_sz  [4] = '{SZ_WORD, SZ_WORD, SZ_LO, SZ_LONG};
    logic [31:0]  alu_res [4] = '{32'h00010000, 32'h00008000, 32'h00000180, 32'h0};
    logic [1:0]   alu_co  [4] = '{2'b10, 2'b01, 2'b00, 2'b11};
    logic [15:0]  alu_exp [4] = '{16'h0005, 16'h0028, 16'h0008, 16'h0025};

    always #5 clk = ~clk;

    crf_core crf_core_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dp_wr(dp_wr), .dp_alu(dp_alu), .dp_pc(dp_pc), .rd_a(rd_a),
        .rd_b(rd_b), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .intr(intr),
        .irq_permit(irq_permit), .flags(flags), .pc(pc));

    crf_dp_model crf_dp_model_inst (.clk(clk), .dp_wr(dp_wr), .dp_alu(dp_alu),
        .dp_pc(dp_pc), .rd_a(rd_a), .rd_b(rd_b), .intr(intr));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test;
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer: setup, access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            stop_test();
        end
    endtask

    // Write with expected error response, read with expected data
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d);
        chk(32'(e), 32'(ee));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, '0);
        chk(r, x);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(OFS_FLG, 32'h0);
        // Same datapath write lands in the bank that the bank flag picks
        crf_dp_model_inst.cyc('{1'b1, SEL_D0, SZ_WORD, 32'hAAAA}, '0, '0, '0, '0);
        wrc(OFS_FLG, 32'h0010, 1'b0);
        crf_dp_model_inst.cyc('{1'b1, SEL_D0, SZ_WORD, 32'h5555}, '0, '0, '0, '0);
        rdc(OFS_BANK0, 32'hAAAA);
        rdc(OFS_BANK1, 32'h5555);
        // Byte halves and the paired long register
        crf_dp_model_inst.cyc('{1'b1, SEL_D0, SZ_HI, 32'hCC}, '0, '0, '0, '0);
        crf_dp_model_inst.cyc('{1'b1, SEL_D0, SZ_LO, 32'h11}, '0, '0, '0, '0);
        crf_dp_model_inst.cyc('0, '0, '0, '{SEL_D0, SZ_WORD}, '0);
        chk(32'(rd_a_data[15:0]), 32'hCC11);
        crf_dp_model_inst.cyc('0, '0, '0, '{SEL_D0, SZ_HI}, '0);
        chk(rd_a_data, 32'h000000CC);
        crf_dp_model_inst.cyc('{1'b1, SEL_D1, SZ_LONG, 32'h89ABCDEF}, '0, '0, '0, '0);
        crf_dp_model_inst.cyc('0, '0, '0, '{SEL_D1, SZ_LONG}, '0);
        chk(rd_b_data, 32'h89ABCDEF);
        rdc(8'h2C, 32'h89AB);
        // Pointers keep 24 bits
        for (int i = 0; i < 7; i++) begin
            wrc(ptr_ofs[i], {8'hFF, 8'(i), 16'h1357}, 1'b0);
            rdc(ptr_ofs[i], {8'h00, 8'(i), 16'h1357});
        end
        // Active stack pointer follows the stack flag; it is read only over APB
        rdc(OFS_ASP, 32'h061357);
        wrc(OFS_FLG, 32'h30C0, 1'b0);
        rdc(OFS_ASP, 32'h051357);
        crf_dp_model_inst.cyc('0, '0, '0, '{SEL_ASP, SZ_WORD}, '0);
        chk(rd_a_data, 32'h00051357);
        crf_dp_model_inst.cyc('{1'b1, SEL_ASP, SZ_WORD, 32'h02468A}, '0, '0, '0, '0);
        rdc(OFS_USP, 32'h02468A);
        wrc(OFS_ASP, 32'h0, 1'b1);
        apb(1'b0, 8'h58, '0);
        chk(32'(e), 32'h1);
        // Program counter loads from the datapath only
        crf_dp_model_inst.cyc('0, '0, '{1'b1, 24'hABCDEF}, '0, '0);
        chk(32'(pc), 32'hABCDEF);
        wrc(OFS_PC, 32'h0, 1'b1);
        rdc(OFS_PC, 32'hABCDEF);
        // Request priority against the level field
        crf_dp_model_inst.cyc('0, '0, '0, '0, '{1'b0, 1'b0, 6'h0, 1'b1, 3'd4});
        chk(32'(irq_permit), 32'h1);
        crf_dp_model_inst.cyc('0, '0, '0, '0, '{1'b0, 1'b0, 6'h0, 1'b1, 3'd3});
        chk(32'(irq_permit), 32'h0);
        // Hardware accept, software vector 32 and 31
        for (int i = 0; i < 3; i++) begin
            wrc(OFS_FLG, 32'h30C0, 1'b0);
            crf_dp_model_inst.cyc('0, '0, '0, '0, '{i == 0, i != 0, 6'(33 - i), 1'b0, 3'd0});
            chk(32'(flags[7:6]), (i == 1) ? 32'h2 : 32'h0);
        end
        crf_dp_model_inst.cyc('0, '0, '0, '0, '{1'b0, 1'b0, 6'h0, 1'b1, 3'd7});
        chk(32'(irq_permit), 32'h0);
        // Condition flags by size
        for (int i = 0; i < 4; i++) begin
            crf_dp_model_inst.cyc('0, '{1'b1, alu_sz[i], alu_res[i], alu_co[i][1],
                                  alu_co[i][0], 4'hF}, '0, '0, '0);
            chk(32'(flags & 16'h002D), 32'(alu_exp[i]));
        end
        stop_test();
    end
endmodule
`default_nettype wire
